/* hdl/dbsc_pkg.sv */
// Shared constants and types for the DDR2 bank-state command legality ends
package dbsc_pkg;
   localparam int NUM_BANKS = 8;
   localparam int BA_W = 3;
   localparam int CNT_W = 8;
   // Command pin levels {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] PIN_NOP = 4'h7;
   localparam logic [3:0] PIN_ACT = 4'h3;
   localparam logic [3:0] PIN_RD = 4'h5;
   localparam logic [3:0] PIN_WR = 4'h4;
   localparam logic [3:0] PIN_PRE = 4'h2;
   localparam logic [3:0] PIN_REF = 4'h1;
   localparam logic [3:0] PIN_LMR = 4'h0;
   localparam logic [3:0] PIN_DESEL = 4'h8;
   // Timing in ns, cycle counts derived at the 100 ns clock (least times round up)
   localparam int CLK_NS = 100;
   localparam int T_RP_NS = 15;
   localparam int T_RCD_NS = 15;
   localparam int T_RFC_NS = 128;
   localparam int T_MRD_NS = 200;
   localparam int BURST_CYC = 2;
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam logic [7:0] RP_CYC = 8'(ns2cyc(T_RP_NS));
   localparam logic [7:0] RCD_CYC = 8'(ns2cyc(T_RCD_NS));
   localparam logic [7:0] RFC_CYC = 8'(ns2cyc(T_RFC_NS));
   localparam logic [7:0] MRD_CYC = 8'(ns2cyc(T_MRD_NS));
   localparam logic [7:0] BST_CYC = 8'(BURST_CYC);
   typedef enum logic [3:0] {
      CMD_NONE, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
      CMD_PRE, CMD_PREA, CMD_REF, CMD_LMR, CMD_BAD
   } dbsc_cmd_t;
   typedef enum logic [3:0] {
      BS_IDLE, BS_PRECHG, BS_ACTIVATING, BS_ACTIVE, BS_READ, BS_WRITE,
      BS_READ_AP, BS_WRITE_AP
   } dbsc_bank_t;
   // Decode the sampled pins; cke low or odd levels yield CMD_BAD/NONE
   function automatic dbsc_cmd_t decode(input logic cke, input logic [3:0] pins,
                                        input logic a10);
      if (pins[3] || pins == PIN_NOP) return CMD_NONE;
      if (!cke) return CMD_BAD;
      case (pins)
         PIN_ACT: return CMD_ACT;
         PIN_RD: return a10 ? CMD_RDA : CMD_RD;
         PIN_WR: return a10 ? CMD_WRA : CMD_WR;
         PIN_PRE: return a10 ? CMD_PREA : CMD_PRE;
         PIN_REF: return CMD_REF;
         PIN_LMR: return CMD_LMR;
         default: return CMD_BAD;
      endcase
   endfunction
endpackage

/* hdl/dbsc_cmd_if.sv */
// Command pins shared by the controller end and the memory end
`timescale 1ns/1ps
interface dbsc_cmd_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic a10;
   logic [dbsc_pkg::BA_W-1:0] ba;
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, a10, ba);
   modport mem (input cke, cs_n, ras_n, cas_n, we_n, a10, ba);
endinterface

/* hdl/dbsc_bank_fsm.sv */
// One bank's state register and timing down-counter
`timescale 1ns/1ps
module dbsc_bank_fsm (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Command aimed at this bank
   input wire logic i_hit,
   input wire dbsc_pkg::dbsc_cmd_t i_cmd,
   // State
   output dbsc_pkg::dbsc_bank_t o_state,
   output logic o_busy
);
   dbsc_pkg::dbsc_bank_t state_ff;
   logic [dbsc_pkg::CNT_W-1:0] cnt_ff;

   assign o_state = state_ff;
   assign o_busy = (cnt_ff != '0);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= dbsc_pkg::BS_IDLE;
         cnt_ff <= '0;
      end else if (i_ce) begin
         if (i_hit) begin
            case (i_cmd)
               dbsc_pkg::CMD_ACT: begin
                  state_ff <= dbsc_pkg::BS_ACTIVATING;
                  cnt_ff <= dbsc_pkg::RCD_CYC;
               end
               dbsc_pkg::CMD_PRE, dbsc_pkg::CMD_PREA: begin
                  state_ff <= dbsc_pkg::BS_PRECHG;
                  cnt_ff <= dbsc_pkg::RP_CYC;
               end
               dbsc_pkg::CMD_RD: begin
                  state_ff <= dbsc_pkg::BS_READ;
                  cnt_ff <= dbsc_pkg::BST_CYC;
               end
               dbsc_pkg::CMD_WR: begin
                  state_ff <= dbsc_pkg::BS_WRITE;
                  cnt_ff <= dbsc_pkg::BST_CYC;
               end
               // Burst plus the auto precharge period, both timed here
               dbsc_pkg::CMD_RDA: begin
                  state_ff <= dbsc_pkg::BS_READ_AP;
                  cnt_ff <= 8'(dbsc_pkg::BST_CYC + dbsc_pkg::RP_CYC);
               end
               dbsc_pkg::CMD_WRA: begin
                  state_ff <= dbsc_pkg::BS_WRITE_AP;
                  cnt_ff <= 8'(dbsc_pkg::BST_CYC + dbsc_pkg::RP_CYC);
               end
               default: begin
               end
            endcase
         end else begin
            if (cnt_ff != '0) begin
               cnt_ff <= cnt_ff - 8'h01;
            end
            // Leave the timed state on the edge the count runs out, not one later
            if (cnt_ff <= 8'h01) begin
               case (state_ff)
                  dbsc_pkg::BS_PRECHG, dbsc_pkg::BS_READ_AP, dbsc_pkg::BS_WRITE_AP:
                     state_ff <= dbsc_pkg::BS_IDLE;
                  dbsc_pkg::BS_ACTIVATING, dbsc_pkg::BS_READ, dbsc_pkg::BS_WRITE:
                     state_ff <= dbsc_pkg::BS_ACTIVE;
                  default: state_ff <= state_ff;
               endcase
            end
         end
      end
   end
endmodule

/* hdl/dbsc_mem_end.sv */
// Memory end: decodes commands, tracks every bank and flags illegal commands
// Notes on behaviour
// - Precharge lasts tRP, then idle
// - Read auto precharge lasts until tRP, idle
// - Activate lasts tRCD, then row active
// - Write auto precharge lasts until tRP, idle
// - Refresh lasts tRFC, then all idle
// - Load mode lasts tMRD, then all idle
// - Precharge all lasts tRP, all idle
// - Only NOP/deselect during global intervals
// - Untabulated combinations are illegal
// - Refresh/load mode only when all idle
// - Multi-bank precharge needs valid bank states
// - Write after read only when burst done
// - CS high deselects; ongoing work continues
// - NOP lets previous operation continue
// - Idle bank n leaves bank m free
// - Busy bank n: ACT/RD/WR/PRE to m
// - Read burst n: ACT/RD/WR/PRE to m
// - Write burst n: ACT/RD/WR/PRE to m
// - Auto and plain forms both allowed
// - Commands sampled from pins at rising edge
`timescale 1ns/1ps
module dbsc_mem_end #(
   parameter int NUM_BANKS = dbsc_pkg::NUM_BANKS
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Command pins
   dbsc_cmd_if.mem cmd,
   // Status
   output logic o_all_idle,
   output logic o_global_busy,
   output logic o_illegal,
   output dbsc_pkg::dbsc_cmd_t o_cmd,
   output logic [dbsc_pkg::BA_W-1:0] o_cmd_bank
);
   initial begin
      if (NUM_BANKS != (1 << dbsc_pkg::BA_W)) $error("NUM_BANKS must match bank address width");
   end

   typedef enum logic [1:0] {GS_NONE, GS_REFRESH, GS_MODE} dbsc_glob_t;

   dbsc_pkg::dbsc_cmd_t cmd_now;
   dbsc_pkg::dbsc_bank_t bank_st [NUM_BANKS];
   logic [NUM_BANKS-1:0] bank_busy;
   logic [NUM_BANKS-1:0] bank_hit;
   logic [NUM_BANKS-1:0] bank_idle;
   logic [NUM_BANKS-1:0] bank_rd;
   logic [NUM_BANKS-1:0] bank_burst;
   dbsc_glob_t glob_ff;
   logic [dbsc_pkg::CNT_W-1:0] gcnt_ff;
   logic legal;
   logic take;
   dbsc_pkg::dbsc_bank_t tgt;

   // Deselect and NOP decode to no command, so no bank is hit and no global interval starts
   assign cmd_now = dbsc_pkg::decode(cmd.cke, {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n},
                                     cmd.a10);
   assign tgt = bank_st[cmd.ba];

   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g++) begin : g_bank
         assign bank_hit[g] = take && ((cmd_now == dbsc_pkg::CMD_PREA) ||
                                       (int'(cmd.ba) == g));
         // Plain bursts may be cut by precharge all
         assign bank_burst[g] = (bank_st[g] == dbsc_pkg::BS_READ) ||
                                (bank_st[g] == dbsc_pkg::BS_WRITE);
         assign bank_idle[g] = (bank_st[g] == dbsc_pkg::BS_IDLE) && !bank_busy[g];
         assign bank_rd[g] = (bank_st[g] == dbsc_pkg::BS_READ) ||
                             (bank_st[g] == dbsc_pkg::BS_READ_AP);
         dbsc_bank_fsm u_bank (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(i_rst_n),
            .i_ce(i_ce),
            .i_hit(bank_hit[g]),
            .i_cmd(cmd_now),
            .o_state(bank_st[g]),
            .o_busy(bank_busy[g])
         );
      end
   endgenerate

   // Legality against the addressed bank; other banks block only refresh, load mode and precharge all
   always_comb begin
      legal = 1'b0;
      if (glob_ff != GS_NONE) begin
         legal = (cmd_now == dbsc_pkg::CMD_NONE);
      end else begin
         case (cmd_now)
            dbsc_pkg::CMD_NONE: legal = 1'b1;
            dbsc_pkg::CMD_ACT: legal = bank_idle[cmd.ba];
            dbsc_pkg::CMD_RD, dbsc_pkg::CMD_RDA:
               legal = !bank_busy[cmd.ba] && (tgt == dbsc_pkg::BS_ACTIVE ||
                       tgt == dbsc_pkg::BS_READ || tgt == dbsc_pkg::BS_WRITE);
            dbsc_pkg::CMD_WR, dbsc_pkg::CMD_WRA:
               legal = !bank_busy[cmd.ba] && (tgt == dbsc_pkg::BS_ACTIVE ||
                       tgt == dbsc_pkg::BS_WRITE);
            dbsc_pkg::CMD_PRE:
               legal = !bank_busy[cmd.ba] || tgt == dbsc_pkg::BS_READ ||
                       tgt == dbsc_pkg::BS_WRITE;
            dbsc_pkg::CMD_PREA:
               legal = !(|(bank_busy & ~bank_burst));
            dbsc_pkg::CMD_REF, dbsc_pkg::CMD_LMR: legal = &bank_idle;
            default: legal = 1'b0;
         endcase
      end
   end
   assign take = legal && (cmd_now != dbsc_pkg::CMD_NONE);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         glob_ff <= GS_NONE;
         gcnt_ff <= '0;
      end else if (i_ce) begin
         if (take && cmd_now == dbsc_pkg::CMD_REF) begin
            glob_ff <= GS_REFRESH;
            gcnt_ff <= dbsc_pkg::RFC_CYC;
         end else if (take && cmd_now == dbsc_pkg::CMD_LMR) begin
            glob_ff <= GS_MODE;
            gcnt_ff <= dbsc_pkg::MRD_CYC;
         end else if (gcnt_ff > 8'h01) begin
            gcnt_ff <= gcnt_ff - 8'h01;
         end else begin
            gcnt_ff <= '0;
            glob_ff <= GS_NONE;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_illegal <= 1'b0;
         o_cmd <= dbsc_pkg::CMD_NONE;
         o_cmd_bank <= '0;
      end else if (i_ce) begin
         o_illegal <= !legal;
         o_cmd <= cmd_now;
         o_cmd_bank <= cmd.ba;
      end
   end

   assign o_all_idle = (&bank_idle) && (glob_ff == GS_NONE);
   assign o_global_busy = (glob_ff != GS_NONE) || (|(bank_busy & ~bank_rd & ~bank_idle));
endmodule

/* hdl/dbsc_ctrl_end.sv */
// Controller end: holds user requests until the target bank can legally take them
`timescale 1ns/1ps
module dbsc_ctrl_end #(
   parameter int NUM_BANKS = dbsc_pkg::NUM_BANKS
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // User request
   input wire logic i_req_valid,
   input wire dbsc_pkg::dbsc_cmd_t i_req_cmd,
   input wire logic [dbsc_pkg::BA_W-1:0] i_req_bank,
   output logic o_req_ready,
   // Command pins
   dbsc_cmd_if.ctrl cmd
);
   initial begin
      if (NUM_BANKS != (1 << dbsc_pkg::BA_W)) $error("NUM_BANKS must match bank address width");
   end

   dbsc_pkg::dbsc_bank_t bank_st [NUM_BANKS];
   logic [NUM_BANKS-1:0] bank_busy;
   logic [NUM_BANKS-1:0] bank_hit;
   logic [NUM_BANKS-1:0] bank_idle;
   logic [NUM_BANKS-1:0] bank_burst;
   logic [dbsc_pkg::CNT_W-1:0] gcnt_ff;
   logic ok;
   logic issue;
   dbsc_pkg::dbsc_bank_t tgt;
   logic [3:0] pins_ff;
   logic a10_ff;
   logic [dbsc_pkg::BA_W-1:0] ba_ff;

   assign tgt = bank_st[i_req_bank];

   // Per-bank state mirror with tRP/tRCD counters
   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g++) begin : g_bank
         assign bank_hit[g] = issue && ((i_req_cmd == dbsc_pkg::CMD_PREA) ||
                                        (int'(i_req_bank) == g));
         assign bank_burst[g] = (bank_st[g] == dbsc_pkg::BS_READ) ||
                                (bank_st[g] == dbsc_pkg::BS_WRITE);
         assign bank_idle[g] = (bank_st[g] == dbsc_pkg::BS_IDLE) && !bank_busy[g];
         dbsc_bank_fsm u_bank (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(i_rst_n),
            .i_ce(i_ce),
            .i_hit(bank_hit[g]),
            .i_cmd(i_req_cmd),
            .o_state(bank_st[g]),
            .o_busy(bank_busy[g])
         );
      end
   endgenerate

   always_comb begin
      ok = 1'b0;
      if (gcnt_ff == '0) begin
         case (i_req_cmd)
            dbsc_pkg::CMD_ACT: ok = bank_idle[i_req_bank];
            dbsc_pkg::CMD_RD, dbsc_pkg::CMD_RDA:
               ok = !bank_busy[i_req_bank] && (tgt == dbsc_pkg::BS_ACTIVE ||
                    tgt == dbsc_pkg::BS_READ || tgt == dbsc_pkg::BS_WRITE);
            dbsc_pkg::CMD_WR, dbsc_pkg::CMD_WRA:
               ok = !bank_busy[i_req_bank] && (tgt == dbsc_pkg::BS_ACTIVE ||
                    tgt == dbsc_pkg::BS_WRITE);
            dbsc_pkg::CMD_PRE:
               ok = !bank_busy[i_req_bank] || tgt == dbsc_pkg::BS_READ ||
                    tgt == dbsc_pkg::BS_WRITE;
            dbsc_pkg::CMD_PREA: ok = !(|(bank_busy & ~bank_burst));
            dbsc_pkg::CMD_REF, dbsc_pkg::CMD_LMR: ok = &bank_idle;
            default: ok = 1'b0;
         endcase
      end
   end
   assign o_req_ready = ok && i_ce;
   assign issue = i_req_valid && o_req_ready;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gcnt_ff <= '0;
      end else if (i_ce) begin
         if (issue && i_req_cmd == dbsc_pkg::CMD_REF) begin
            gcnt_ff <= dbsc_pkg::RFC_CYC;
         end else if (issue && i_req_cmd == dbsc_pkg::CMD_LMR) begin
            gcnt_ff <= dbsc_pkg::MRD_CYC;
         end else if (gcnt_ff != '0) begin
            gcnt_ff <= gcnt_ff - 8'h01;
         end
      end
   end

   // Pins other than cke are registered; NOP is driven in every i_ce cycle where nothing is issued, else pins hold
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pins_ff <= dbsc_pkg::PIN_NOP;
         a10_ff <= 1'b0;
         ba_ff <= '0;
      end else if (i_ce) begin
         ba_ff <= i_req_bank;
         a10_ff <= (i_req_cmd == dbsc_pkg::CMD_RDA) || (i_req_cmd == dbsc_pkg::CMD_WRA) ||
                   (i_req_cmd == dbsc_pkg::CMD_PREA);
         if (!issue) begin
            pins_ff <= dbsc_pkg::PIN_NOP;
         end else begin
            case (i_req_cmd)
               dbsc_pkg::CMD_ACT: pins_ff <= dbsc_pkg::PIN_ACT;
               dbsc_pkg::CMD_RD, dbsc_pkg::CMD_RDA: pins_ff <= dbsc_pkg::PIN_RD;
               dbsc_pkg::CMD_WR, dbsc_pkg::CMD_WRA: pins_ff <= dbsc_pkg::PIN_WR;
               dbsc_pkg::CMD_PRE, dbsc_pkg::CMD_PREA: pins_ff <= dbsc_pkg::PIN_PRE;
               dbsc_pkg::CMD_REF: pins_ff <= dbsc_pkg::PIN_REF;
               dbsc_pkg::CMD_LMR: pins_ff <= dbsc_pkg::PIN_LMR;
               default: pins_ff <= dbsc_pkg::PIN_NOP;
            endcase
         end
      end
   end

   assign cmd.cke = 1'b1;
   assign {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} = pins_ff;
   assign cmd.a10 = a10_ff;
   assign cmd.ba = ba_ff;
endmodule

/* tb/dbsc_link_checker.sv */
// Assertions on the command link between the two ends
`timescale 1ns/1ps
module dbsc_link_checker (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Command pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic a10,
   input wire logic [dbsc_pkg::BA_W-1:0] ba,
   // Memory end status
   input wire logic o_all_idle,
   input wire logic o_global_busy,
   input wire logic o_illegal,
   input wire dbsc_pkg::dbsc_cmd_t o_cmd,
   input wire logic [dbsc_pkg::BA_W-1:0] o_cmd_bank
);
   logic [3:0] pins;
   logic quiet;
   assign pins = {cs_n, ras_n, cas_n, we_n};
   assign quiet = cs_n | (pins == dbsc_pkg::PIN_NOP);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   a_ref_quiet: assert property (pins == dbsc_pkg::PIN_REF |=> quiet [*2])
      else $error("command inside refresh");
   a_mode_quiet: assert property (pins == dbsc_pkg::PIN_LMR |=> quiet [*2])
      else $error("command inside mode access");
   a_prea_quiet: assert property (pins == dbsc_pkg::PIN_PRE && a10 |=> quiet)
      else $error("command inside precharge all");
   a_act_hold: assert property (pins == dbsc_pkg::PIN_ACT |=>
      !((pins == dbsc_pkg::PIN_RD || pins == dbsc_pkg::PIN_WR) && ba == $past(ba)))
      else $error("access before activate done");
   a_rd_then_wr: assert property (pins == dbsc_pkg::PIN_RD |=>
      !(pins == dbsc_pkg::PIN_WR && ba == $past(ba)))
      else $error("write inside read burst");
   a_ref_idle: assert property (pins == dbsc_pkg::PIN_REF |-> o_all_idle)
      else $error("refresh with a bank busy");
   a_link_legal: assert property (!o_illegal)
      else $error("illegal command on link");
   a_desel_none: assert property (cs_n |=> o_cmd == dbsc_pkg::CMD_NONE)
      else $error("deselect decoded as command");
   a_act_decode: assert property (pins == dbsc_pkg::PIN_ACT && cke |=>
      o_cmd == dbsc_pkg::CMD_ACT && o_cmd_bank == $past(ba) && o_global_busy)
      else $error("activate decode wrong");
   c_ref: cover property (pins == dbsc_pkg::PIN_REF);
   c_mode: cover property (pins == dbsc_pkg::PIN_LMR);
   c_prea: cover property (pins == dbsc_pkg::PIN_PRE && a10);
endmodule

/* tb/tb_top.sv */
// Bench: controller end drives memory end; a second memory end takes bad pins
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys;
   logic i_rst_n;
   logic req_valid, req_ready, all_idle, busy, ill, bad_ill;
   dbsc_pkg::dbsc_cmd_t req_cmd, mcmd, bad_cmd;
   logic [2:0] req_bank, mbank;
   int n_fail = 0;
   int n_tests = 0;
   dbsc_cmd_if link();
   dbsc_cmd_if bad();
   dbsc_ctrl_end u_dbsc_ctrl_end (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .i_req_valid(req_valid), .i_req_cmd(req_cmd), .i_req_bank(req_bank),
      .o_req_ready(req_ready), .cmd(link.ctrl));
   dbsc_mem_end u_dbsc_mem_end (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .cmd(link.mem), .o_all_idle(all_idle), .o_global_busy(busy), .o_illegal(ill),
      .o_cmd(mcmd), .o_cmd_bank(mbank));
   dbsc_mem_end u_dbsc_mem_end_bad (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .cmd(bad.mem), .o_all_idle(), .o_global_busy(), .o_illegal(bad_ill),
      .o_cmd(bad_cmd), .o_cmd_bank());
   dbsc_link_checker u_dbsc_link_checker (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
      .we_n(link.we_n), .a10(link.a10), .ba(link.ba), .o_all_idle(all_idle),
      .o_global_busy(busy), .o_illegal(ill), .o_cmd(mcmd), .o_cmd_bank(mbank));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Every task starts and ends at a falling edge; the next one takes over the request
   task automatic issue(input dbsc_pkg::dbsc_cmd_t c, input logic [2:0] b, input logic [4:0] p);
      int i;
      req_cmd = c;
      req_bank = b;
      req_valid = 1'b1;
      #1;
      for (i = 0; i < 30 && req_ready !== 1'b1; i++) begin
         @(negedge i_clk_sys);
         #1;
      end
      if (i == 30) begin
         n_fail++;
         conclude();
      end
      @(negedge i_clk_sys);
      check("pins", {link.a10, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba}, {p, b});
   endtask
   task automatic refused(input dbsc_pkg::dbsc_cmd_t c, input logic [2:0] b);
      req_cmd = c;
      req_bank = b;
      req_valid = 1'b1;
      #1;
      check("ready", {7'h0, req_ready}, 8'h00);
      req_valid = 1'b0;
      @(negedge i_clk_sys);
   endtask
   // Pins held one cycle; the flag is read while it stands
   task automatic drive_bad(input logic [4:0] p, input logic [2:0] b, input logic exp_ill);
      {bad.a10, bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n} = p;
      bad.ba = b;
      @(negedge i_clk_sys);
      check("flag", {7'h0, bad_ill}, {7'h0, exp_ill});
   endtask
   task automatic s_banks();
      issue(dbsc_pkg::CMD_ACT, 3'd2, 5'h03);
      refused(dbsc_pkg::CMD_RD, 3'd2);
      issue(dbsc_pkg::CMD_ACT, 3'd5, 5'h03);
      issue(dbsc_pkg::CMD_RDA, 3'd2, 5'h15);
      issue(dbsc_pkg::CMD_WR, 3'd5, 5'h04);
      refused(dbsc_pkg::CMD_ACT, 3'd2);
      issue(dbsc_pkg::CMD_PRE, 3'd5, 5'h02);
      refused(dbsc_pkg::CMD_ACT, 3'd5);
      issue(dbsc_pkg::CMD_ACT, 3'd2, 5'h03);
      issue(dbsc_pkg::CMD_ACT, 3'd1, 5'h03);
      issue(dbsc_pkg::CMD_RD, 3'd1, 5'h05);
      refused(dbsc_pkg::CMD_WR, 3'd1);
      issue(dbsc_pkg::CMD_WRA, 3'd1, 5'h14);
      issue(dbsc_pkg::CMD_PREA, 3'd0, 5'h12);
      refused(dbsc_pkg::CMD_ACT, 3'd6);
   endtask
   task automatic s_global();
      issue(dbsc_pkg::CMD_ACT, 3'd0, 5'h03);
      refused(dbsc_pkg::CMD_REF, 3'd0);
      issue(dbsc_pkg::CMD_PRE, 3'd0, 5'h02);
      issue(dbsc_pkg::CMD_REF, 3'd0, 5'h01);
      refused(dbsc_pkg::CMD_ACT, 3'd3);
      check("busy", {7'h0, busy}, 8'h01);
      repeat (4) @(negedge i_clk_sys);
      check("idle", {7'h0, all_idle}, 8'h01);
      issue(dbsc_pkg::CMD_LMR, 3'd0, 5'h00);
      refused(dbsc_pkg::CMD_ACT, 3'd3);
      repeat (4) @(negedge i_clk_sys);
      check("idle", {7'h0, all_idle}, 8'h01);
   endtask
   task automatic s_bad();
      drive_bad(5'h04, 3'd3, 1'b1);
      drive_bad(5'h0A, 3'd3, 1'b0);
      drive_bad(5'h03, 3'd4, 1'b0);
      check("decoded", bad_cmd, dbsc_pkg::CMD_ACT);
      drive_bad(5'h01, 3'd0, 1'b1);
      drive_bad(5'h05, 3'd4, 1'b0);
      drive_bad(5'h04, 3'd4, 1'b1);
      drive_bad(5'h12, 3'd0, 1'b0);
      drive_bad(5'h00, 3'd0, 1'b1);
      {bad.a10, bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n, bad.ba} = 8'h3F;
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      i_rst_n = 1'b0;
      req_valid = 1'b0;
      req_cmd = dbsc_pkg::CMD_NONE;
      req_bank = 3'd0;
      {bad.cke, bad.a10, bad.cs_n, bad.ras_n, bad.cas_n, bad.we_n, bad.ba} = 9'h138;
      repeat (8) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      check("nop", {3'h0, link.cs_n, link.ras_n, link.cas_n, link.we_n}, 8'h07);
      check("decoded", mcmd, dbsc_pkg::CMD_NONE);
      s_banks();
      s_global();
      s_bad();
      req_valid = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      conclude();
   end
endmodule
